// ===== hw/mfs_pkg.sv
// Notes on behaviour
// - overvoltage trip: FETs off, pin low, flags
// - resume after overvoltage; flag held till clear
// - register variant: enable bit, 22/34 V select
// - pin variant: overvoltage always on, 34 V
// - overcurrent needs deglitch; response per mode
// - pin variant: fixed deglitch, latched, pin level
// - mode 00: latched shutdown until clear
// - mode 01: retry restarts, flags stay latched
// - mode 10: report only, FETs keep running
// - mode 11: overcurrent ignored entirely
// - buck overcurrent: buck off, retry clears flags
// - thermal warning sets flags, no action
// - warning on pin if enabled, hysteresis release
// - warning flag clears on clear below trip
// - FET overtemp: FETs, pump off; auto resume
// - die overtemp also stops buck; latch flag
// - long sleep low enters sleep, all off
// - sleep high: operating after wake delay
// - fault pin low during power transitions
// - clear by command or short sleep pulse
// - sleep pulse clears faults, keeps settings; FETs off while low
package mfs_pkg;
  localparam int CLK_PERIOD_NS = 8;
  localparam int OC_DEG_PIN_NS = 600;
  localparam int OC_DEG_PIN_CYC = (OC_DEG_PIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_NS = 4000;
  localparam int RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BK_RETRY_NS = 4000;
  localparam int BK_RETRY_CYC = (BK_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BK_DEG_NS = 400;
  localparam int BK_DEG_CYC = (BK_DEG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_WIN_NS = 1600;
  localparam int RST_WIN_CYC = RST_WIN_NS / CLK_PERIOD_NS;
  localparam int SLEEP_NS = 2400;
  localparam int SLEEP_CYC = SLEEP_NS / CLK_PERIOD_NS;
  localparam int WAKE_NS = 2000;
  localparam int WAKE_CYC = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [4:0] CTRL_OFS = 5'h00;
  localparam logic [4:0] FILT_OFS = 5'h04;
  localparam logic [4:0] SUMMARY_OFS = 5'h08;
  localparam logic [4:0] STAT_OFS = 5'h0c;
  localparam logic [4:0] MODE_OFS = 5'h10;

  localparam int CTRL_OV_EN = 0;
  localparam int CTRL_OV_SEL = 1;
  localparam int CTRL_OC_RESP = 2;
  localparam int CTRL_WARN_PIN = 4;
  localparam int CTRL_CLEAR = 5;
  localparam int CTRL_OC_LVL = 6;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] FILT_RST = 8'h4b;

  localparam logic [1:0] OC_LATCH = 2'h0;
  localparam logic [1:0] OC_RETRY = 2'h1;
  localparam logic [1:0] OC_REPORT = 2'h2;
  localparam logic [1:0] OC_OFF = 2'h3;

  localparam int SYNC_W = 15;
  localparam logic [14:0] SYNC_RST = 15'h4000;

  typedef enum logic [1:0] {PW_RUN, PW_LOW, PW_SLEEP, PW_WAKE} mfs_pwr_t;
endpackage : mfs_pkg

// ===== hw/mfs_top.sv
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module mfs_top #(
  parameter bit PIN_VARIANT = 1'b0,
  parameter int CW = 16,
  parameter int RETRY_CYCLES = mfs_pkg::RETRY_CYC,
  parameter int BK_RETRY_CYCLES = mfs_pkg::BK_RETRY_CYC,
  parameter int BK_DEG_CYCLES = mfs_pkg::BK_DEG_CYC,
  parameter int RST_WIN_CYCLES = mfs_pkg::RST_WIN_CYC,
  parameter int SLEEP_CYCLES = mfs_pkg::SLEEP_CYC,
  parameter int WAKE_CYCLES = mfs_pkg::WAKE_CYC
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SLEEP_IN_N,
  input wire logic OV_ABOVE_22,
  input wire logic OV_ABOVE_34,
  input wire logic [5:0] FET_OC,
  input wire logic BUCK_OC,
  input wire logic TEMP_WARN,
  input wire logic TEMP_WARN_HYS,
  input wire logic TEMP_FET_SD,
  input wire logic TEMP_DIE_SD,
  input wire logic OC_SLEW_PIN,
  output logic FAULT_OUT_N_O,
  output logic FAULT_OUT_N_OE,
  output logic FET_EN,
  output logic BUCK_EN,
  output logic CHARGE_PUMP_EN,
  output logic CSA_EN,
  output logic ANALOG_REG_EN,
  output logic SERIAL_EN,
  output logic READY,
  output logic [1:0] OC_LEVEL
);
  import mfs_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end else begin
      sync1_reg <= {SLEEP_IN_N, OV_ABOVE_22, OV_ABOVE_34, FET_OC, BUCK_OC, TEMP_WARN,
                    TEMP_WARN_HYS, TEMP_FET_SD, TEMP_DIE_SD, OC_SLEW_PIN};
      sync2_reg <= sync1_reg;
    end
  end

  logic sleep_s, ov22_s, ov34_s, buck_s, warn_s, warn_hys_s, fet_sd_s, die_sd_s, slew_s;
  logic [5:0] fet_s;
  assign {sleep_s, ov22_s, ov34_s, fet_s, buck_s, warn_s, warn_hys_s, fet_sd_s, die_sd_s,
          slew_s} = sync2_reg;

  // ************************************************************
  // register bus
  // ************************************************************
  logic ack_reg, wait_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] filt_reg;
  logic clear_cmd_reg;
  logic [31:0] rdata_reg;
  mfs_pwr_t pwr_reg;
  logic pulse_clear_reg;
  logic wr_go;

  assign wr_go = ack_reg & AVS_WRITE & AVS_BYTEENABLE[0] & (pwr_reg != PW_SLEEP);

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
    end else begin
      ack_reg <= (AVS_READ | AVS_WRITE) & !ack_reg;
      wait_reg <= !((AVS_READ | AVS_WRITE) & !ack_reg);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N || pwr_reg == PW_SLEEP) begin
      ctrl_reg <= CTRL_RST;
      filt_reg <= FILT_RST;
    end else if (wr_go && AVS_ADDRESS == CTRL_OFS) begin
      ctrl_reg <= AVS_WRITEDATA[7:0] & ~(8'h01 << CTRL_CLEAR);
    end else if (wr_go && AVS_ADDRESS == FILT_OFS) begin
      filt_reg <= AVS_WRITEDATA[7:0];
    end
  end

  // one-cycle clear from command or short sleep pulse
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      clear_cmd_reg <= 1'b0;
    end else begin
      clear_cmd_reg <= (wr_go && AVS_ADDRESS == CTRL_OFS && AVS_WRITEDATA[CTRL_CLEAR]) ||
                       pulse_clear_reg;
    end
  end

  // ************************************************************
  // configuration as seen by protection
  // ************************************************************
  logic ov_active, ov_trip, ov_now;
  logic [1:0] oc_mode;
  logic [7:0] oc_thr;

  assign ov_active = PIN_VARIANT ? 1'b1 : ctrl_reg[CTRL_OV_EN];
  assign ov_trip = (PIN_VARIANT || ctrl_reg[CTRL_OV_SEL]) ? ov34_s : ov22_s;
  assign ov_now = ov_active & ov_trip;
  assign oc_mode = PIN_VARIANT ? OC_LATCH : ctrl_reg[CTRL_OC_RESP +: 2];
  assign oc_thr = PIN_VARIANT ? 8'(OC_DEG_PIN_CYC) : filt_reg;

  // ************************************************************
  // overcurrent deglitch per FET
  // ************************************************************
  logic [5:0] fet_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_deg
      logic [7:0] cnt_reg;
      always_ff @(posedge MCLK) begin
        if (!RST_N || !fet_s[gi]) begin
          cnt_reg <= 8'h00;
        end else if (cnt_reg != oc_thr) begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
      assign fet_hit[gi] = fet_s[gi] && cnt_reg == oc_thr;
    end
  endgenerate

  logic oc_cond, oc_act;
  assign oc_cond = |fet_hit;
  assign oc_act = oc_cond && oc_mode != OC_OFF;

  // ************************************************************
  // overcurrent response
  // ************************************************************
  logic oc_pin_reg;
  logic [CW-1:0] oc_retry_reg;
  logic oc_expire;

  assign oc_expire = oc_pin_reg && oc_mode == OC_RETRY && oc_retry_reg == CW'(RETRY_CYCLES);

  always_ff @(posedge MCLK) begin
    if (!RST_N || !oc_pin_reg || oc_mode != OC_RETRY) begin
      oc_retry_reg <= '0;
    end else if (!oc_expire) begin
      oc_retry_reg <= oc_retry_reg + CW'(1);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      oc_pin_reg <= 1'b0;
    end else if (oc_expire) begin
      oc_pin_reg <= 1'b0;
    end else if (oc_act) begin
      oc_pin_reg <= 1'b1;
    end else if (clear_cmd_reg && oc_mode != OC_RETRY) begin
      oc_pin_reg <= 1'b0;
    end
  end

  // ************************************************************
  // buck overcurrent with retry
  // ************************************************************
  logic [CW-1:0] bk_deg_reg;
  logic [CW-1:0] bk_retry_reg;
  logic bk_off_reg;
  logic bk_hit;

  assign bk_hit = buck_s && bk_deg_reg == CW'(BK_DEG_CYCLES);

  always_ff @(posedge MCLK) begin
    if (!RST_N || !buck_s) begin
      bk_deg_reg <= '0;
    end else if (!bk_hit) begin
      bk_deg_reg <= bk_deg_reg + CW'(1);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N || !bk_off_reg) begin
      bk_retry_reg <= '0;
    end else begin
      bk_retry_reg <= bk_retry_reg + CW'(1);
    end
  end

  // flags and buck shutdown share this latch
  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      bk_off_reg <= 1'b0;
    end else if (bk_off_reg && bk_retry_reg == CW'(BK_RETRY_CYCLES)) begin
      bk_off_reg <= 1'b0;
    end else if (bk_hit) begin
      bk_off_reg <= 1'b1;
    end
  end

  // ************************************************************
  // latched flags
  // ************************************************************
  logic any_flag_reg, ov_flag_reg, oc_flag_reg, ot_flag_reg, warn_flag_reg, sd_flag_reg;
  logic warn_pin_reg;
  logic [5:0] fet_flag_reg;
  logic thermal_any;

  assign thermal_any = warn_s | fet_sd_s | die_sd_s;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      any_flag_reg <= 1'b0;
    end else if (ov_now || oc_act || bk_hit || fet_sd_s || die_sd_s) begin
      any_flag_reg <= 1'b1;
    end else if (clear_cmd_reg) begin
      any_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ov_flag_reg <= 1'b0;
    end else if (ov_now) begin
      ov_flag_reg <= 1'b1;
    end else if (clear_cmd_reg) begin
      ov_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      oc_flag_reg <= 1'b0;
      fet_flag_reg <= 6'h00;
    end else if (clear_cmd_reg && !oc_act) begin
      oc_flag_reg <= 1'b0;
      fet_flag_reg <= 6'h00;
    end else if (oc_act) begin
      oc_flag_reg <= 1'b1;
      fet_flag_reg <= fet_flag_reg | fet_hit;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ot_flag_reg <= 1'b0;
    end else if (thermal_any) begin
      ot_flag_reg <= 1'b1;
    end else if (clear_cmd_reg) begin
      ot_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      warn_flag_reg <= 1'b0;
    end else if (warn_s) begin
      warn_flag_reg <= 1'b1;
    end else if (clear_cmd_reg) begin
      warn_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      warn_pin_reg <= 1'b0;
    end else if (warn_s && ctrl_reg[CTRL_WARN_PIN]) begin
      warn_pin_reg <= 1'b1;
    end else if (!warn_hys_s || !ctrl_reg[CTRL_WARN_PIN]) begin
      warn_pin_reg <= 1'b0;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      sd_flag_reg <= 1'b0;
    end else if (fet_sd_s || die_sd_s) begin
      sd_flag_reg <= 1'b1;
    end else if (clear_cmd_reg) begin
      sd_flag_reg <= 1'b0;
    end
  end

  // ************************************************************
  // sleep pin sequencing
  // ************************************************************
  logic [CW-1:0] pwr_cnt_reg;
  logic ready_reg;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      pwr_reg <= PW_WAKE;
      pwr_cnt_reg <= '0;
      pulse_clear_reg <= 1'b0;
    end else begin
      pulse_clear_reg <= 1'b0;
      pwr_cnt_reg <= pwr_cnt_reg + CW'(1);
      case (pwr_reg)
        PW_RUN: begin
          pwr_cnt_reg <= '0;
          if (!sleep_s) begin
            pwr_reg <= PW_LOW;
          end
        end
        PW_LOW: begin
          if (sleep_s) begin
            pwr_reg <= PW_RUN;
            pulse_clear_reg <= pwr_cnt_reg < CW'(RST_WIN_CYCLES);
          end else if (pwr_cnt_reg >= CW'(SLEEP_CYCLES)) begin
            pwr_reg <= PW_SLEEP;
          end
        end
        PW_SLEEP: begin
          pwr_cnt_reg <= '0;
          if (sleep_s) begin
            pwr_reg <= PW_WAKE;
          end
        end
        default: begin
          if (!sleep_s) begin
            pwr_reg <= PW_SLEEP;
            pwr_cnt_reg <= '0;
          end else if (pwr_cnt_reg >= CW'(WAKE_CYCLES)) begin
            pwr_reg <= PW_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= pwr_reg == PW_RUN || pwr_reg == PW_LOW;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic pwr_on, transition, oc_fet_off;

  assign pwr_on = pwr_reg != PW_SLEEP;
  assign transition = pwr_reg == PW_WAKE ||
                      (pwr_reg == PW_LOW && pwr_cnt_reg >= CW'(RST_WIN_CYCLES));
  assign oc_fet_off = oc_pin_reg && oc_mode != OC_REPORT;

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      FAULT_OUT_N_O <= 1'b0;
      FAULT_OUT_N_OE <= 1'b0;
      FET_EN <= 1'b0;
      BUCK_EN <= 1'b0;
      CHARGE_PUMP_EN <= 1'b0;
      CSA_EN <= 1'b0;
      ANALOG_REG_EN <= 1'b0;
      SERIAL_EN <= 1'b0;
      OC_LEVEL <= 2'h0;
    end else begin
      FAULT_OUT_N_O <= 1'b0;
      FAULT_OUT_N_OE <= ov_now || oc_pin_reg || bk_off_reg || warn_pin_reg || fet_sd_s ||
                        die_sd_s || transition;
      FET_EN <= pwr_reg == PW_RUN && !ov_now && !oc_fet_off && !fet_sd_s &&
                !die_sd_s;
      BUCK_EN <= pwr_on && !bk_off_reg && !die_sd_s;
      CHARGE_PUMP_EN <= pwr_on && !fet_sd_s && !die_sd_s;
      CSA_EN <= pwr_on;
      ANALOG_REG_EN <= pwr_on;
      SERIAL_EN <= pwr_on;
      OC_LEVEL <= PIN_VARIANT ? {1'b0, slew_s} : ctrl_reg[CTRL_OC_LVL +: 2];
    end
  end

  assign READY = ready_reg;

  function automatic logic [31:0] rd_mux(input logic [4:0] a);
    if (a == CTRL_OFS) begin
      rd_mux = {24'h0, ctrl_reg};
    end else if (a == FILT_OFS) begin
      rd_mux = {24'h0, filt_reg};
    end else if (a == SUMMARY_OFS) begin
      rd_mux = {27'h0, bk_off_reg, oc_flag_reg, ov_flag_reg, ot_flag_reg, any_flag_reg};
    end else if (a == STAT_OFS) begin
      rd_mux = {23'h0, fet_flag_reg, bk_off_reg, sd_flag_reg, warn_flag_reg};
    end else if (a == MODE_OFS) begin
      rd_mux = {29'h0, ready_reg, pwr_reg};
    end else begin
      rd_mux = 32'h0;
    end
  endfunction

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      rdata_reg <= 32'h0;
    end else if (AVS_READ && !ack_reg) begin
      rdata_reg <= rd_mux(AVS_ADDRESS);
    end
  end

  assign AVS_READDATA = rdata_reg;
  assign AVS_WAITREQUEST = wait_reg;
endmodule : mfs_top

// ===== test/mfs_host_model.sv
`timescale 1ns/1ps
// ****************************************
// external controller on sleep and fault pins
// ****************************************
module mfs_host_model (
  input wire logic fault_o,
  input wire logic fault_oe,
  output logic sleep_n,
  output logic fault_line
);
  // pull-up holds the line high unless the device sinks it
  assign fault_line = fault_oe ? fault_o : 1'b1;
  initial sleep_n = 1'b1;
  task automatic lower();
    sleep_n <= 1'b0;
  endtask : lower
  task automatic raise();
    sleep_n <= 1'b1;
  endtask : raise
endmodule : mfs_host_model

// ===== test/mfs_top_asserts.sv
`timescale 1ns/1ps
// ****************************************
// fault and power-mode checks
// ****************************************
module mfs_top_asserts #(
  parameter int RST_WIN_CYCLES = 10,
  parameter int SLEEP_CYCLES = 20,
  parameter int WAKE_CYCLES = 10
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic AVS_WAITREQUEST,
  input wire logic SLEEP_IN_N,
  input wire logic OV_ABOVE_34,
  input wire logic TEMP_FET_SD,
  input wire logic TEMP_DIE_SD,
  input wire logic FAULT_OUT_N_OE,
  input wire logic FET_EN,
  input wire logic BUCK_EN,
  input wire logic CHARGE_PUMP_EN,
  input wire logic CSA_EN,
  input wire logic ANALOG_REG_EN,
  input wire logic SERIAL_EN,
  input wire logic READY
);
  logic [1:0] ov_reg;
  logic [15:0] lo_reg;
  logic [15:0] hi_reg;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // shadow of the overvoltage control bits, lost on sleep
  always_ff @(posedge MCLK) begin
    if (!RST_N || !SERIAL_EN) ov_reg <= 2'h0;
    else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == 5'h00 && AVS_BYTEENABLE[0])
      ov_reg <= AVS_WRITEDATA[1:0];
  end
  // consecutive cycles of the sleep pin low and high
  always_ff @(posedge MCLK) begin
    if (!RST_N) lo_reg <= 16'h0;
    else lo_reg <= SLEEP_IN_N ? 16'h0 : lo_reg + {15'h0, ~&lo_reg};
  end
  always_ff @(posedge MCLK) begin
    if (!RST_N) hi_reg <= 16'h0;
    else hi_reg <= !SLEEP_IN_N ? 16'h0 : hi_reg + {15'h0, ~&hi_reg};
  end
  sequence s_buck_off;
    !BUCK_EN [*8];
  endsequence
  fet_temp_off_a: assert property (TEMP_FET_SD [*5] |->
    !FET_EN && !CHARGE_PUMP_EN && FAULT_OUT_N_OE) else $error("fet overtemp not handled");
  die_temp_off_a: assert property (TEMP_DIE_SD [*5] |->
    !FET_EN && !BUCK_EN && FAULT_OUT_N_OE) else $error("die overtemp not handled");
  ov_trip_off_a: assert property (ov_reg == 2'h3 && OV_ABOVE_34 [*5] |->
    !FET_EN && FAULT_OUT_N_OE) else $error("overvoltage trip missed");
  sleep_all_off_a: assert property (lo_reg == SLEEP_CYCLES + 6 |->
    !(FET_EN | BUCK_EN | CHARGE_PUMP_EN | CSA_EN | ANALOG_REG_EN | SERIAL_EN))
    else $error("sleep left a block enabled");
  pulse_keeps_a: assert property (SERIAL_EN && !SLEEP_IN_N && lo_reg < RST_WIN_CYCLES
    |=> SERIAL_EN) else $error("short low dropped the regulators");
  ready_late_a: assert property ($rose(READY) |-> hi_reg >= WAKE_CYCLES)
    else $error("ready before wake delay");
  wake_bound_a: assert property (hi_reg == WAKE_CYCLES + 10 |-> READY)
    else $error("wake not finished in time");
  buck_retry_a: assert property ($fell(BUCK_EN) && SLEEP_IN_N && !TEMP_DIE_SD
    && !$past(TEMP_DIE_SD, 3) |=> s_buck_off) else $error("buck retry too short");
endmodule : mfs_top_asserts

bind mfs_top mfs_top_asserts #(.RST_WIN_CYCLES(RST_WIN_CYCLES), .SLEEP_CYCLES(SLEEP_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)) u_asserts (.MCLK(MCLK), .RST_N(RST_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SLEEP_IN_N(SLEEP_IN_N), .OV_ABOVE_34(OV_ABOVE_34), .TEMP_FET_SD(TEMP_FET_SD),
  .TEMP_DIE_SD(TEMP_DIE_SD), .FAULT_OUT_N_OE(FAULT_OUT_N_OE), .FET_EN(FET_EN),
  .BUCK_EN(BUCK_EN), .CHARGE_PUMP_EN(CHARGE_PUMP_EN), .CSA_EN(CSA_EN),
  .ANALOG_REG_EN(ANALOG_REG_EN), .SERIAL_EN(SERIAL_EN), .READY(READY));

// ===== test/mfs_top_tb.sv
`timescale 1ns/1ps
// ****************************************
// fault and sleep controller bench
// ****************************************
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module mfs_top_tb;
  import mfs_pkg::*;
  localparam int RW = 10;
  localparam int SL = 20;
  logic MCLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SLEEP_IN_N, OV_ABOVE_22;
  logic OV_ABOVE_34, BUCK_OC, TEMP_WARN, TEMP_WARN_HYS, TEMP_FET_SD, TEMP_DIE_SD;
  logic FAULT_OUT_N_O, FAULT_OUT_N_OE, FET_EN, BUCK_EN, CHARGE_PUMP_EN, CSA_EN;
  logic ANALOG_REG_EN, SERIAL_EN, READY, fault_line, OC_SLEW_PIN;
  logic [4:0] AVS_ADDRESS;
  logic [3:0] AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [5:0] FET_OC, pat;
  logic [1:0] OC_LEVEL;
  logic [7:0] cv;
  int errors = 0, cmp_count = 0, cyc = 0, seed, m, i;
  mfs_top #(.RETRY_CYCLES(8), .BK_RETRY_CYCLES(8), .BK_DEG_CYCLES(3), .RST_WIN_CYCLES(RW),
    .SLEEP_CYCLES(SL), .WAKE_CYCLES(10)) u_mfs_top (.MCLK, .RST_N, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .SLEEP_IN_N, .OV_ABOVE_22, .OV_ABOVE_34, .FET_OC, .BUCK_OC, .TEMP_WARN, .TEMP_WARN_HYS,
    .TEMP_FET_SD, .TEMP_DIE_SD, .OC_SLEW_PIN, .FAULT_OUT_N_O, .FAULT_OUT_N_OE,
    .FET_EN, .BUCK_EN, .CHARGE_PUMP_EN, .CSA_EN, .ANALOG_REG_EN, .SERIAL_EN, .READY,
    .OC_LEVEL);
  mfs_host_model u_mfs_host_model (.fault_o(FAULT_OUT_N_O), .fault_oe(FAULT_OUT_N_OE),
    .sleep_n(SLEEP_IN_N), .fault_line(fault_line));
  initial begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  task end_of_test();
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  task bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    AVS_ADDRESS <= a;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    AVS_WRITEDATA <= {24'h0, d};
    do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    @(posedge MCLK);
  endtask : bus
  task wt(input int n);
    repeat (n) @(posedge MCLK);
  endtask : wt
  task clr(input logic [7:0] c);
    bus(1'b1, CTRL_OFS, c | 8'h20);
    wt(3);
  endtask : clr
  task rdy();
    do @(posedge MCLK); while (READY !== 1'b1);
  endtask : rdy
  function logic [31:0] f_ctrl(input logic [7:0] w);
    return {24'h0, w & 8'hdf};
  endfunction : f_ctrl
  function logic f_trip(input logic [2:0] k);
    return k[2] && (k[1] ? k[0] : 1'b1);
  endfunction : f_trip
  initial begin
    seed = 16781;
    {AVS_READ, AVS_WRITE, OV_ABOVE_22, OV_ABOVE_34, BUCK_OC, TEMP_WARN} = '0;
    {TEMP_WARN_HYS, TEMP_FET_SD, TEMP_DIE_SD, RST_N} = '0;
    AVS_ADDRESS = '0;
    AVS_WRITEDATA = '0;
    AVS_BYTEENABLE = 4'hf;
    OC_SLEW_PIN = 1'b0;
    FET_OC = '0;
    wt(2);
    RST_N <= 1'b1;
    rdy();
    bus(1'b0, CTRL_OFS, 8'h0); `CHK(q, 32'h0)
    bus(1'b1, 5'h14, 8'hff); bus(1'b0, 5'h14, 8'h0); `CHK(q, 32'h0)
    bus(1'b0, FILT_OFS, 8'h0); `CHK(q, {24'h0, FILT_RST})
    for (i = 0; i < 4; i++) begin
      cv = 8'($random(seed));
      OC_SLEW_PIN <= 1'($random(seed));
      bus(1'b1, CTRL_OFS, cv); bus(1'b0, CTRL_OFS, 8'h0); `CHK(q, f_ctrl(cv))
      `CHK(OC_LEVEL, cv[7:6])
    end
    // write with lane 0 disabled must leave the settings alone
    AVS_BYTEENABLE <= 4'he;
    bus(1'b1, CTRL_OFS, 8'hff);
    AVS_BYTEENABLE <= 4'hf;
    bus(1'b0, CTRL_OFS, 8'h0); `CHK(q, f_ctrl(cv))
    for (i = 0; i < 8; i++) begin
      bus(1'b1, CTRL_OFS, {4'h0, 2'h3, i[1], i[2]});
      OV_ABOVE_22 <= 1'b1;
      OV_ABOVE_34 <= i[0];
      wt(8); `CHK({FET_EN, fault_line}, {2{!f_trip(i[2:0])}})
      {OV_ABOVE_22, OV_ABOVE_34} <= 2'h0;
      wt(8); `CHK({FET_EN, fault_line}, 2'h3)
      bus(1'b0, SUMMARY_OFS, 8'h0); `CHK(q[2], f_trip(i[2:0]))
      clr(8'h0c); bus(1'b0, SUMMARY_OFS, 8'h0); `CHK(q, 32'h0)
    end
    for (m = 0; m < 4; m++) begin
      pat = 6'($random(seed)) | 6'h1;
      bus(1'b1, FILT_OFS, {6'h0, 2'($random(seed))} + 8'h3);
      bus(1'b1, CTRL_OFS, {4'h0, m[1:0], 2'h0});
      FET_OC <= pat; wt(2); FET_OC <= 6'h0; wt(6);
      `CHK(fault_line, 1'b1)
      FET_OC <= pat; wt(12);
      `CHK(FET_EN, m[1])
      `CHK(fault_line, m == 3)
      FET_OC <= 6'h0;
      bus(1'b0, STAT_OFS, 8'h0); `CHK(q[8:3], (m == 3) ? 6'h0 : pat)
      wt(20); `CHK({FET_EN, fault_line}, {m != 0, m[0]})
      bus(1'b0, SUMMARY_OFS, 8'h0); `CHK(q[3], m != 3)
      clr({4'h0, m[1:0], 2'h0}); `CHK({FET_EN, fault_line}, 2'h3)
      bus(1'b0, STAT_OFS, 8'h0); `CHK(q, 32'h0)
    end
    BUCK_OC <= 1'b1; wt(8); `CHK({BUCK_EN, fault_line}, 2'h0)
    BUCK_OC <= 1'b0;
    bus(1'b0, SUMMARY_OFS, 8'h0); `CHK(q[4], 1'b1)
    wt(20); `CHK({BUCK_EN, fault_line}, 2'h3)
    bus(1'b0, STAT_OFS, 8'h0); `CHK(q[2], 1'b0)
    clr(8'h0c);
    TEMP_WARN <= 1'b1;
    TEMP_WARN_HYS <= 1'b1;
    wt(6); `CHK({FET_EN, fault_line}, 2'h3)
    bus(1'b0, STAT_OFS, 8'h0); `CHK(q[0], 1'b1)
    clr(8'h1c); `CHK(fault_line, 1'b0)
    bus(1'b0, STAT_OFS, 8'h0); `CHK(q[0], 1'b1)
    TEMP_WARN <= 1'b0; wt(6); `CHK(fault_line, 1'b0)
    TEMP_WARN_HYS <= 1'b0; wt(6); `CHK(fault_line, 1'b1)
    clr(8'h0c); bus(1'b0, STAT_OFS, 8'h0); `CHK(q, 32'h0)
    for (i = 0; i < 2; i++) begin
      TEMP_FET_SD <= !i[0];
      TEMP_DIE_SD <= i[0];
      wt(8); `CHK({FET_EN, CHARGE_PUMP_EN, BUCK_EN, fault_line}, {2'h0, !i[0], 1'b0})
      {TEMP_FET_SD, TEMP_DIE_SD} <= 2'h0;
      wt(8); `CHK({FET_EN, fault_line}, 2'h3)
      bus(1'b0, STAT_OFS, 8'h0); `CHK(q[1], 1'b1)
      clr(8'h0c); bus(1'b0, STAT_OFS, 8'h0); `CHK(q[1], 1'b0)
    end
    bus(1'b1, CTRL_OFS, 8'h0d);
    OV_ABOVE_22 <= 1'b1; wt(6); OV_ABOVE_22 <= 1'b0; wt(6);
    bus(1'b0, SUMMARY_OFS, 8'h0); `CHK(q[2], 1'b1)
    u_mfs_host_model.lower(); wt(RW / 2); u_mfs_host_model.raise(); wt(6);
    bus(1'b0, SUMMARY_OFS, 8'h0); `CHK(q, 32'h0)
    bus(1'b0, CTRL_OFS, 8'h0); `CHK(q, 32'h0d)
    `CHK({BUCK_EN, SERIAL_EN}, 2'h3)
    u_mfs_host_model.lower(); wt(SL + 8);
    `CHK({FET_EN, BUCK_EN, CHARGE_PUMP_EN, CSA_EN, ANALOG_REG_EN, SERIAL_EN}, 6'h0)
    u_mfs_host_model.raise(); wt(6); `CHK(fault_line, 1'b0)
    rdy(); wt(2); `CHK({fault_line, SERIAL_EN}, 2'h3)
    bus(1'b0, CTRL_OFS, 8'h0); `CHK(q, 32'h0)
    end_of_test();
  end
endmodule : mfs_top_tb
